// ===== core/reload_capture_timer16.sv
// two identical reload/capture timers behind one wishbone slave, bank chosen by a map bit
`timescale 1ns/1ps
`include "reload_capture_timer16_regs.svh"
module reload_capture_timer16
   import reload_capture_timer16_pkg::*;
(
   input  wire logic                                  clk_i,
   input  wire logic                                  rst_i,
   input  wire logic                                  ce_i,
   input  wire reload_capture_timer16_pkg::wb_req_t   wb_req_i,
   output reload_capture_timer16_pkg::wb_rsp_t        wb_rsp_o,
   input  wire reload_capture_timer16_pkg::timer_pins_t pins0_i,
   input  wire reload_capture_timer16_pkg::timer_pins_t pins1_i,
   output logic                                       irq_o
);
   import reload_capture_timer16_pkg::*;

   bus_state_t  bus_q;                     // slave state
   logic        sfr_map_select_q;          // bank select bit
   logic [3:0]  ctrl_q [2];                // per-instance control
   logic [1:0]  mode_q [2];                // per-instance mode
   logic [1:0]  stat_q [2];                // sticky pending flags
   logic [1:0]  mask_q [2];                // interrupt enables
   logic [15:0] count_w [2];               // live counts
   logic [15:0] reload_w [2];              // live reload/capture values
   timer_evt_t  evt_w [2];                 // event pulses
   timer_pins_t pins_w [2];                // pin bundles
   logic        wr_stb;                    // write accepted this cycle
   logic [31:0] rdata;                     // read mux
   logic [1:0]  wlo;                       // byte lanes 0/1 flags

   // offset match, used by the write paths only; the read mux decodes with a case
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign pins_w[0] = pins0_i;
   assign pins_w[1] = pins1_i;
   // a write lands at the edge where the master samples ack, while its request still stands
   assign wr_stb = (bus_q == BUS_ACK) && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we;
   assign wlo = wb_req_i.sel[1:0];

   // wishbone slave: ack one cycle after request, dropped next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_q        <= BUS_IDLE;
         wb_rsp_o.ack <= 1'b0;
         wb_rsp_o.dat <= 32'h0000_0000;
      end else begin
         case (bus_q)
            BUS_IDLE: begin
               if (wb_req_i.cyc && wb_req_i.stb) begin
                  bus_q        <= BUS_ACK;
                  wb_rsp_o.ack <= 1'b1;
                  wb_rsp_o.dat <= wb_req_i.we ? 32'h0000_0000 : rdata;
               end
            end
            BUS_ACK: begin
               bus_q        <= BUS_IDLE;
               wb_rsp_o.ack <= 1'b0;
            end
            default: begin
               bus_q        <= BUS_IDLE;
               wb_rsp_o.ack <= 1'b0;
            end
         endcase
      end
   end

   // map select, shared by both banks so it lives outside them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sfr_map_select_q <= 1'b0;
      end else if (wr_stb && wlo[0] && hit(wb_req_i.adr, `TMR_OFF_MAPSEL)) begin
         sfr_map_select_q <= wb_req_i.dat[0];
      end
   end

   // per-instance registers and cores
   for (genvar i = 0; i < 2; i++) begin : g_inst
      logic sel_me;                        // this bank is addressed
      logic [1:0] w1c;                     // write-one-to-clear bits
      assign sel_me = wr_stb && (sfr_map_select_q == 1'(i));
      assign w1c = (sel_me && wlo[0] && hit(wb_req_i.adr, `TMR_OFF_STATUS)) ? wb_req_i.dat[1:0] : 2'b00;

      // control, mode and mask
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ctrl_q[i] <= `TMR_CTRL_RST;
            mode_q[i] <= `TMR_MODE_RST;
            mask_q[i] <= `TMR_STAT_RST;
         end else if (sel_me && wlo[0]) begin
            if (hit(wb_req_i.adr, `TMR_OFF_CTRL)) begin
               ctrl_q[i] <= wb_req_i.dat[3:0];
            end
            if (hit(wb_req_i.adr, `TMR_OFF_MODE)) begin
               mode_q[i] <= wb_req_i.dat[1:0];
            end
            if (hit(wb_req_i.adr, `TMR_OFF_MASK)) begin
               mask_q[i] <= wb_req_i.dat[1:0];
            end
         end
      end

      // sticky flags; a new event beats a clear in the same cycle
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            stat_q[i] <= `TMR_STAT_RST;
         end else begin
            stat_q[i] <= (stat_q[i] & ~w1c) | {evt_w[i].capture, evt_w[i].reload};
         end
      end

      timer16_core u_core (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .ce_i        (ce_i),
         .pins_i      (pins_w[i]),
         .ctrl_i      (ctrl_q[i]),
         .mode_i      (mode_q[i]),
         .rv_we_i     (sel_me && (wlo != 2'b00) && hit(wb_req_i.adr, `TMR_OFF_RELOAD)),
         .rv_wdata_i  ({wlo[1] ? wb_req_i.dat[15:8] : reload_w[i][15:8],
                        wlo[0] ? wb_req_i.dat[7:0]  : reload_w[i][7:0]}),
         .cnt_we_i    (sel_me && (wlo != 2'b00) && hit(wb_req_i.adr, `TMR_OFF_COUNT)),
         .cnt_wdata_i ({wlo[1] ? wb_req_i.dat[15:8] : count_w[i][15:8],
                        wlo[0] ? wb_req_i.dat[7:0]  : count_w[i][7:0]}),
         .count_o     (count_w[i]),
         .reload_o    (reload_w[i]),
         .evt_o       (evt_w[i])
      );
   end

   // read mux for the selected bank; unmapped offsets read zero
   always_comb begin
      logic b;
      b = sfr_map_select_q;
      rdata = 32'h0000_0000;
      case (wb_req_i.adr)
         `TMR_OFF_CTRL:   rdata[3:0]  = ctrl_q[b];
         `TMR_OFF_MODE:   rdata[1:0]  = mode_q[b];
         `TMR_OFF_RELOAD: rdata[15:0] = reload_w[b];
         `TMR_OFF_COUNT:  rdata[15:0] = count_w[b];
         `TMR_OFF_STATUS: rdata[1:0]  = stat_q[b];
         `TMR_OFF_MASK:   rdata[1:0]  = mask_q[b];
         `TMR_OFF_MAPSEL: rdata[0]    = sfr_map_select_q;
         default:         rdata       = 32'h0000_0000;
      endcase
   end

   // level interrupt, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_q[0] & mask_q[0]) || |(stat_q[1] & mask_q[1]);
      end
   end
endmodule

// ===== core/reload_capture_timer16_pkg.sv
// types shared by the reload/capture timer files
package reload_capture_timer16_pkg;

   // one wishbone classic request
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   // the slave answer
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // the two external pins of one instance
   typedef struct packed {
      logic count_input;
      logic ext_trigger_input;
   } timer_pins_t;

   // event pulses from one timer core
   typedef struct packed {
      logic reload;
      logic capture;
   } timer_evt_t;

   // bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;

endpackage

// ===== core/reload_capture_timer16_regs.svh
// register offsets, field positions, reset values and timing counts of the reload/capture timer
`ifndef RELOAD_CAPTURE_TIMER16_REGS_SVH
`define RELOAD_CAPTURE_TIMER16_REGS_SVH

// word offsets on the wishbone bus, the map select bit selects the instance
`define TMR_OFF_CTRL      8'h00
`define TMR_OFF_MODE      8'h04
`define TMR_OFF_RELOAD    8'h08
`define TMR_OFF_COUNT     8'h0C
`define TMR_OFF_STATUS    8'h10
`define TMR_OFF_MASK      8'h14
`define TMR_OFF_MAPSEL    8'h18

// control register fields
`define TMR_CTRL_RUN      0
`define TMR_CTRL_COUNTER  1
`define TMR_CTRL_CAPTURE  2
`define TMR_CTRL_TRIGEN   3
// mode register fields
`define TMR_MODE_UPDOWN   0
`define TMR_MODE_EDGE     1
// status / mask fields
`define TMR_ST_RELOAD     0
`define TMR_ST_CAPTURE    1

// reset values
`define TMR_CTRL_RST      4'h0
`define TMR_MODE_RST      2'h0
`define TMR_VAL_RST       16'h0000
`define TMR_STAT_RST      2'h0

// count limits
`define TMR_TOP           16'hFFFF
`define TMR_BOTTOM        16'h0000

// timing: timer tick each twelve peripheral clocks, pins sampled as often, an edge needs two samples
`define TMR_TICK_DIV      4'd12
`define TMR_PIN_DIV       4'd12

`endif

// ===== core/timer16_core.sv
// one 16-bit reload/capture counter core with pin sampling
`timescale 1ns/1ps
`include "reload_capture_timer16_regs.svh"
module timer16_core
   import reload_capture_timer16_pkg::*;
(
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   input  wire logic                               ce_i,
   input  wire reload_capture_timer16_pkg::timer_pins_t pins_i,
   input  wire logic [3:0]                         ctrl_i,
   input  wire logic [1:0]                         mode_i,
   input  wire logic                               rv_we_i,
   input  wire logic [15:0]                        rv_wdata_i,
   input  wire logic                               cnt_we_i,
   input  wire logic [15:0]                        cnt_wdata_i,
   output logic [15:0]                             count_o,
   output logic [15:0]                             reload_o,
   output reload_capture_timer16_pkg::timer_evt_t  evt_o
);
   logic [3:0]  pre_q;        // twelve-cycle prescale for timer ticks
   logic [3:0]  smp_q;        // sampler divider for the pins
   logic        cnt_s_q;      // last sampled count pin
   logic        trg_s_q;      // last sampled trigger pin
   logic        trg_p_q;      // previous sampled trigger
   logic        fall_q;       // count pin fall seen
   logic        trg_edge;     // selected trigger edge
   logic        tick;         // one count step
   logic        up;           // direction this step
   logic        smp_stb;      // pin sample strobe
   logic        ovf;          // counting up from top
   logic        unf;          // counting down from reload value

   // tick divider, twelve clocks per timer step
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= 4'h0;
      end else if (ce_i) begin
         if (pre_q == `TMR_TICK_DIV - 4'd1) begin
            pre_q <= 4'h0;
         end else begin
            pre_q <= pre_q + 4'd1;
         end
      end
   end

   // pins sampled once per twelve clocks, an edge needs two samples: 24 clocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         smp_q <= 4'h0;
      end else if (ce_i) begin
         if (smp_q == `TMR_PIN_DIV - 4'd1) begin
            smp_q <= 4'h0;
         end else begin
            smp_q <= smp_q + 4'd1;
         end
      end
   end
   assign smp_stb = ce_i && (smp_q == `TMR_PIN_DIV - 4'd1);

   // pin samplers and edge memory
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_s_q <= 1'b1;
         trg_s_q <= 1'b1;
         trg_p_q <= 1'b1;
         fall_q  <= 1'b0;
      end else if (smp_stb) begin
         cnt_s_q <= pins_i.count_input;
         fall_q  <= cnt_s_q && !pins_i.count_input;
         trg_s_q <= pins_i.ext_trigger_input;
         trg_p_q <= trg_s_q;
      end else if (ce_i) begin
         fall_q <= 1'b0;
      end
   end

   // edge select: 0 falling, 1 rising
   assign trg_edge = smp_stb && (mode_i[`TMR_MODE_EDGE] ? (trg_s_q && !trg_p_q) : (!trg_s_q && trg_p_q));
   assign tick = ce_i && ctrl_i[`TMR_CTRL_RUN] &&
                 (ctrl_i[`TMR_CTRL_COUNTER] ? fall_q : (pre_q == `TMR_TICK_DIV - 4'd1));
   // direction by trigger level only in up/down reload mode
   assign up  = ctrl_i[`TMR_CTRL_CAPTURE] || !mode_i[`TMR_MODE_UPDOWN] || trg_s_q;
   assign ovf = up && (count_o == `TMR_TOP);
   assign unf = !up && (count_o == reload_o);

   // counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= `TMR_VAL_RST;
      end else if (cnt_we_i) begin
         count_o <= cnt_wdata_i;
      end else if (ce_i) begin
         if (ctrl_i[`TMR_CTRL_CAPTURE]) begin
            if (tick) begin
               count_o <= ovf ? `TMR_BOTTOM : count_o + 16'h0001;
            end
         end else if (mode_i[`TMR_MODE_UPDOWN]) begin
            if (tick) begin
               if (ovf) begin
                  count_o <= reload_o;
               end else if (unf) begin
                  count_o <= `TMR_TOP;
               end else begin
                  count_o <= up ? count_o + 16'h0001 : count_o - 16'h0001;
               end
            end
         end else if ((tick && ovf) || (ctrl_i[`TMR_CTRL_TRIGEN] && trg_edge)) begin
            count_o <= reload_o;
         end else if (tick) begin
            count_o <= count_o + 16'h0001;
         end
      end
   end

   // reload/capture value, captured in capture mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_o <= `TMR_VAL_RST;
      end else if (ce_i && ctrl_i[`TMR_CTRL_CAPTURE] && ctrl_i[`TMR_CTRL_TRIGEN] && trg_edge) begin
         reload_o <= count_o;
      end else if (rv_we_i) begin
         reload_o <= rv_wdata_i;
      end
   end

   // event pulses; none in up/down mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_o <= '0;
      end else if (ce_i) begin
         evt_o.capture <= ctrl_i[`TMR_CTRL_CAPTURE] && ctrl_i[`TMR_CTRL_TRIGEN] && trg_edge;
         evt_o.reload  <= !(!ctrl_i[`TMR_CTRL_CAPTURE] && mode_i[`TMR_MODE_UPDOWN]) &&
                          ((tick && ovf) || (!ctrl_i[`TMR_CTRL_CAPTURE] && ctrl_i[`TMR_CTRL_TRIGEN] && trg_edge));
      end else begin
         evt_o <= '0;
      end
   end
endmodule

// ===== tb/pin_source.sv
// external pulse source for the count and trigger pins
`timescale 1ns/1ps
module pin_source
   import reload_capture_timer16_pkg::*;
#(
   parameter int HOLD = 24 // cycles each level stands
)(
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   input  wire logic                               go_i,
   input  wire logic [7:0]                         npulse_i,
   input  wire logic                               trig_i,
   output reload_capture_timer16_pkg::timer_pins_t pins_o,
   output logic                                    busy_o
);
   logic [7:0] left_q; // low pulses still to finish
   logic [7:0] ph_q;   // cycles spent at the current level
   logic       lvl_q;  // count line, idles high like a pulled-up pin
   // level sequencer: a level shorter than two samples could be missed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_q <= 8'h00;
         ph_q <= 8'h00;
         lvl_q <= 1'b1;
      end else if (left_q == 8'h00) begin
         ph_q <= 8'h00;
         if (go_i) left_q <= npulse_i;
      end else if (ph_q == 8'(HOLD - 1)) begin
         ph_q <= 8'h00;
         lvl_q <= ~lvl_q;
         if (!lvl_q) left_q <= left_q - 8'h01;
      end else begin
         ph_q <= ph_q + 8'h01;
      end
   end
   assign pins_o = '{count_input: lvl_q, ext_trigger_input: trig_i};
   assign busy_o = (left_q != 8'h00);
endmodule

// ===== tb/reload_capture_timer16_properties.sv
// port checks of the reload/capture timer: bus answer and interrupt hold
`timescale 1ns/1ps
`include "reload_capture_timer16_regs.svh"
module timer_bus_checker
   import reload_capture_timer16_pkg::*;
(
   input  wire logic                                    clk_i,
   input  wire logic                                    rst_i,
   input  wire logic                                    ce_i,
   input  wire reload_capture_timer16_pkg::wb_req_t     wb_req_i,
   input  wire reload_capture_timer16_pkg::wb_rsp_t     wb_rsp_o,
   input  wire reload_capture_timer16_pkg::timer_pins_t pins0_i,
   input  wire reload_capture_timer16_pkg::timer_pins_t pins1_i,
   input  wire logic                                    irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd; // a read at the edge of its answer
   logic wr; // a write at the edge of its answer
   assign rd = wb_rsp_o.ack && !wb_req_i.we;
   assign wr = wb_rsp_o.ack && wb_req_i.we;
   // a fresh request is answered one cycle later
   property p_ack_answer; wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered in one cycle");
   // ack stands for one cycle only
   property p_ack_pulse; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");
   // no answer without a request
   property p_ack_cause; $rose(wb_rsp_o.ack) |-> $past(wb_req_i.cyc && wb_req_i.stb); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   // offsets above the map select read as zero
   property p_unmapped; rd && wb_req_i.adr > `TMR_OFF_MAPSEL |-> wb_rsp_o.dat == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // control holds four bits only
   property p_ctrl_width; rd && wb_req_i.adr == `TMR_OFF_CTRL |-> wb_rsp_o.dat[31:4] == 28'h000_0000; endproperty
   a_ctrl_width: assert property (p_ctrl_width) else $error("control read too wide");
   // count and reload values are sixteen bits
   property p_val_width;
      rd && (wb_req_i.adr == `TMR_OFF_COUNT || wb_req_i.adr == `TMR_OFF_RELOAD) |-> wb_rsp_o.dat[31:16] == 16'h0000;
   endproperty
   a_val_width: assert property (p_val_width) else $error("value read too wide");
   // status carries only the reload and capture flags
   property p_stat_width; rd && wb_req_i.adr == `TMR_OFF_STATUS |-> wb_rsp_o.dat[31:2] == 30'h0; endproperty
   a_stat_width: assert property (p_stat_width) else $error("status read too wide");
   // map select is one bit
   property p_map_width; rd && wb_req_i.adr == `TMR_OFF_MAPSEL |-> wb_rsp_o.dat[31:1] == 31'h0; endproperty
   a_map_width: assert property (p_map_width) else $error("map select read too wide");
   // a pending interrupt drops only within three cycles after a bus write
   property p_irq_hold; $fell(irq_o) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3); endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped on its own");
endmodule

// ===== tb/tb.sv
// self-checking bench of the reload/capture timer
`timescale 1ns/1ps
`include "reload_capture_timer16_regs.svh"
module tb;
   import reload_capture_timer16_pkg::*;
   logic        clk_i, rst_i, ce_i, go, trig, busy, irq;
   logic [7:0]  npulse;
   logic [15:0] v, w;
   wb_req_t     req_q;
   wb_rsp_t     rsp;
   timer_pins_t pins;
   logic [31:0] exp_q[$]; // expected read data, oldest first
   int          miscompares, checks_done, seed;
   reload_capture_timer16 i_reload_capture_timer16 (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req_q),
      .wb_rsp_o(rsp), .pins0_i(pins), .pins1_i(pins), .irq_o(irq));
   pin_source i_pin_source (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .npulse_i(npulse), .trig_i(trig),
      .pins_o(pins), .busy_o(busy));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle: hold until ack is sampled, then release
   // no cycle count assumed: only the watchdog ends a wait that never sees ack
   task automatic bus(input logic [7:0] adr, input logic we, input logic [31:0] dat);
      @(posedge clk_i);
      req_q <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3, dat: dat};
      do begin
         @(posedge clk_i);
      end while (rsp.ack !== 1'b1);
      check({31'h0, rsp.ack}, 32'h0000_0001);
      req_q <= '0;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      bus(adr, 1'b1, dat);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(adr, 1'b0, 32'h0000_0000);
   endtask
   // timers see ce for exactly 12*k edges, so k steps whatever the divider phase
   task automatic run_ticks(input int k);
      @(posedge clk_i);
      ce_i <= 1'b1;
      repeat (12 * k) @(posedge clk_i);
      ce_i <= 1'b0;
   endtask
   task automatic chk_irq(input logic e);
      repeat (3) @(posedge clk_i);
      check({31'h0, irq}, {31'h0, e});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // read monitor: each answered read takes the oldest note
   always @(posedge clk_i) begin
      if (rsp.ack === 1'b1 && req_q.we === 1'b0 && exp_q.size() > 0) check(rsp.dat, exp_q.pop_front());
   end
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      seed = 84739;
      rst_i = 1'b1;
      ce_i = 1'b0;
      go = 1'b0;
      trig = 1'b0;
      npulse = 8'h00;
      req_q = '0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0000_0000);
      v = 16'($random(seed)) & 16'hFFF0; // seven steps must not reach the overflow
      w = 16'($random(seed)) & 16'h7FFF;
      wr(`TMR_OFF_COUNT, 32'(v));
      wr(`TMR_OFF_CTRL, 32'h0000_0001);
      run_ticks(7);
      rd(`TMR_OFF_COUNT, 32'(16'(v + 16'h0007)));
      wr(`TMR_OFF_RELOAD, 32'(w));
      wr(`TMR_OFF_COUNT, 32'h0000_FFFE);
      wr(`TMR_OFF_STATUS, 32'h0000_0003);
      wr(`TMR_OFF_MASK, 32'h0000_0001);
      run_ticks(3);
      rd(`TMR_OFF_COUNT, 32'(w + 16'h0001));
      rd(`TMR_OFF_STATUS, 32'h0000_0001);
      chk_irq(1'b1);
      wr(`TMR_OFF_MASK, 32'h0000_0000);
      chk_irq(1'b0);
      wr(`TMR_OFF_MASK, 32'h0000_0001);
      chk_irq(1'b1);
      wr(`TMR_OFF_STATUS, 32'h0000_0001);
      rd(`TMR_OFF_STATUS, 32'h0000_0000);
      chk_irq(1'b0);
      // up/down: trigger low counts down to the reload value, then jumps to the top
      wr(`TMR_OFF_MODE, 32'h0000_0001);
      wr(`TMR_OFF_COUNT, 32'(w + 16'h0002));
      run_ticks(3);
      rd(`TMR_OFF_COUNT, 32'h0000_FFFF);
      trig <= 1'b1;
      run_ticks(2);
      wr(`TMR_OFF_COUNT, 32'h0000_FFFF);
      run_ticks(1);
      rd(`TMR_OFF_COUNT, 32'(w));
      rd(`TMR_OFF_STATUS, 32'h0000_0000);
      chk_irq(1'b0);
      // counter mode on the count pin
      wr(`TMR_OFF_MODE, 32'h0000_0000);
      wr(`TMR_OFF_CTRL, 32'h0000_0003);
      wr(`TMR_OFF_COUNT, 32'h0000_0000);
      @(posedge clk_i);
      ce_i <= 1'b1;
      npulse <= 8'h05;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      for (int n = 0; n < 2000 && busy; n++) @(posedge clk_i);
      repeat (48) @(posedge clk_i);
      rd(`TMR_OFF_COUNT, 32'h0000_0005);
      // trigger reload and capture, both edges
      for (int i = 0; i < 4; i++) begin
         trig <= ~i[0];
         repeat (48) @(posedge clk_i);
         v = 16'($random(seed));
         wr(`TMR_OFF_MODE, {30'h0, i[0], 1'b0});
         wr(`TMR_OFF_CTRL, i[1] ? 32'h0000_000F : 32'h0000_000B);
         wr(`TMR_OFF_COUNT, 32'(v));
         wr(`TMR_OFF_RELOAD, 32'(w));
         wr(`TMR_OFF_STATUS, 32'h0000_0003);
         trig <= i[0];
         repeat (48) @(posedge clk_i);
         if (i[1]) begin
            rd(`TMR_OFF_RELOAD, 32'(v));
            rd(`TMR_OFF_STATUS, 32'h0000_0002);
         end else begin
            rd(`TMR_OFF_COUNT, 32'(w));
            rd(`TMR_OFF_STATUS, 32'h0000_0001);
         end
      end
      // capture mode wraps to zero on overflow
      ce_i <= 1'b0;
      wr(`TMR_OFF_CTRL, 32'h0000_0005);
      wr(`TMR_OFF_COUNT, 32'h0000_FFFF);
      wr(`TMR_OFF_STATUS, 32'h0000_0003);
      run_ticks(2);
      rd(`TMR_OFF_COUNT, 32'h0000_0001);
      rd(`TMR_OFF_STATUS, 32'h0000_0001);
      // second instance behind the map bit, and an ignored write to a hole
      wr(`TMR_OFF_MAPSEL, 32'h0000_0001);
      wr(`TMR_OFF_COUNT, 32'(w));
      rd(`TMR_OFF_MAPSEL, 32'h0000_0001);
      rd(`TMR_OFF_COUNT, 32'(w));
      wr(`TMR_OFF_MAPSEL, 32'h0000_0000);
      rd(`TMR_OFF_COUNT, 32'h0000_0001);
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, 32'h0000_0000);
      repeat (4) @(posedge clk_i);
      tally_and_finish();
   end
endmodule
bind reload_capture_timer16 timer_bus_checker i_timer_bus_checker (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pins0_i(pins0_i), .pins1_i(pins1_i), .irq_o(irq_o));
